// ==== fkas_top.sv ====
// Flash key, erase-code select and array select register bank
//
// The AXI4-Lite slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module fkas_top
    import fkas_pkg::*;
(
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic RST_B,
    // AXI4-Lite register bus
    input wire logic [31:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [31:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    // Operating mode straps
    input wire fkas_mode_t MODE,
    // Download engine side
    input wire logic RAM_EMULATION_ON,
    input wire logic EXEC_FROM_RAM,
    input wire logic DOWNLOAD_REQUEST_WR,
    input wire logic DOWNLOAD_DONE,
    // Flash control outputs
    output logic DOWNLOAD_REQUEST,
    output logic ERASE_PROGRAM_PICK,
    output logic PROG_ERASE_EN,
    output logic SOFT_PROTECT,
    output logic USER_BOOT_SELECT
);
    fkas_wr_t wr;
    logic [3:0] rd_addr;
    logic [7:0] rd_data;
    logic rd_hit;
    fkas_mode_t mode;
    logic mode_valid;
    logic erase_pick_reg;
    logic [7:0] flash_key_reg;
    logic [7:0] array_select_reg;
    logic download_request_reg;
    logic boot_allowed;
    logic wr_ecs;
    logic wr_key;
    logic wr_ams;

    // ==========================================================
    // Bus slave and mode capture
    fkas_axi_slave u_axi (
        .clk(CORE_CLK),
        .rst_b(RST_B),
        .awaddr(S_AXI_AWADDR),
        .awvalid(S_AXI_AWVALID),
        .awready(S_AXI_AWREADY),
        .wdata(S_AXI_WDATA),
        .wstrb(S_AXI_WSTRB),
        .wvalid(S_AXI_WVALID),
        .wready(S_AXI_WREADY),
        .bresp(S_AXI_BRESP),
        .bvalid(S_AXI_BVALID),
        .bready(S_AXI_BREADY),
        .araddr(S_AXI_ARADDR),
        .arvalid(S_AXI_ARVALID),
        .arready(S_AXI_ARREADY),
        .rdata(S_AXI_RDATA),
        .rresp(S_AXI_RRESP),
        .rvalid(S_AXI_RVALID),
        .rready(S_AXI_RREADY),
        .wr(wr),
        .rd_addr(rd_addr),
        .rd_data(rd_data),
        .rd_hit(rd_hit)
    );

    fkas_mode_latch u_mode (
        .clk(CORE_CLK),
        .rst_b(RST_B),
        .mode_in(MODE),
        .mode(mode),
        .valid(mode_valid)
    );

    assign wr_ecs = wr.en && (wr.addr == ERASE_CODE_SELECT_OFS);
    assign wr_key = wr.en && (wr.addr == FLASH_KEY_OFS);
    assign wr_ams = wr.en && (wr.addr == ARRAY_SELECT_OFS);

    // boot array only in user-boot, boot and programmer modes
    assign boot_allowed = (mode == FKAS_MODE_USER_BOOT)
        || (mode == FKAS_MODE_BOOT) || (mode == FKAS_MODE_PROGRAMMER);

    // ==========================================================
    // Erase-code select register
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            erase_pick_reg <= ERASE_CODE_SELECT_RST[ERASE_PICK_BIT];
        end else if (wr_ecs) begin
            erase_pick_reg <= wr.data[ERASE_PICK_BIT];
        end else if (DOWNLOAD_DONE) begin
            erase_pick_reg <= 1'b0;
        end
    end

    // ==========================================================
    // Key register
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            flash_key_reg <= FLASH_KEY_RST;
        end else if (wr_key) begin
            flash_key_reg <= wr.data;
        end
    end

    // ==========================================================
    // Array select register
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            array_select_reg <= ARRAY_SELECT_RST_OTHER;
        end else if (!mode_valid) begin
            array_select_reg <= (MODE == FKAS_MODE_USER_BOOT)
                ? ARRAY_SELECT_RST_BOOT : ARRAY_SELECT_RST_OTHER;
        end else if (wr_ams) begin
            array_select_reg <= wr.data;
        end
    end

    // ==========================================================
    // Download request
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            download_request_reg <= 1'b0;
        end else if (DOWNLOAD_REQUEST_WR && !RAM_EMULATION_ON
                     && EXEC_FROM_RAM && flash_key_reg == KEY_DOWNLOAD) begin
            download_request_reg <= 1'b1;
        end else if (DOWNLOAD_DONE) begin
            download_request_reg <= 1'b0;
        end
    end

    // ==========================================================
    // Outputs
    assign DOWNLOAD_REQUEST = download_request_reg;
    assign ERASE_PROGRAM_PICK = erase_pick_reg;
    assign PROG_ERASE_EN = (flash_key_reg == KEY_PROGRAM);
    assign SOFT_PROTECT = (flash_key_reg != KEY_PROGRAM);
    assign USER_BOOT_SELECT = boot_allowed
        && (array_select_reg == ARRAY_BOOT_CODE);

    // ==========================================================
    // Read mux
    always_comb begin
        rd_data = 8'h00;
        rd_hit = 1'b1;
        case (rd_addr)
            ERASE_CODE_SELECT_OFS: rd_data = {7'h00, erase_pick_reg};
            FLASH_KEY_OFS: rd_data = flash_key_reg;
            ARRAY_SELECT_OFS: rd_data = array_select_reg;
            STATUS_OFS: begin
                rd_data[STAT_DL_EN_BIT] = (flash_key_reg == KEY_DOWNLOAD);
                rd_data[STAT_PE_EN_BIT] = PROG_ERASE_EN;
                rd_data[STAT_PROTECT_BIT] = SOFT_PROTECT;
                rd_data[STAT_BOOT_SEL_BIT] = USER_BOOT_SELECT;
            end
            default: rd_hit = 1'b0;
        endcase
    end
endmodule : fkas_top

// ==== fkas_pkg.sv ====
// Package with register map, codes and types of the flash key block
package fkas_pkg;
    // ==========================================================
    // Register offsets (byte addresses)
    localparam logic [3:0] ERASE_CODE_SELECT_OFS = 4'h0;
    localparam logic [3:0] FLASH_KEY_OFS = 4'h4;
    localparam logic [3:0] ARRAY_SELECT_OFS = 4'h8;
    localparam logic [3:0] STATUS_OFS = 4'hC;
    // ==========================================================
    // Field positions and codes
    localparam int ERASE_PICK_BIT = 0;
    localparam int STAT_DL_EN_BIT = 0;
    localparam int STAT_PE_EN_BIT = 1;
    localparam int STAT_PROTECT_BIT = 2;
    localparam int STAT_BOOT_SEL_BIT = 3;
    localparam logic [7:0] KEY_DOWNLOAD = 8'hA5;
    localparam logic [7:0] KEY_PROGRAM = 8'h5A;
    localparam logic [7:0] ARRAY_BOOT_CODE = 8'hAA;
    // ==========================================================
    // Reset values
    localparam logic [7:0] ERASE_CODE_SELECT_RST = 8'h00;
    localparam logic [7:0] FLASH_KEY_RST = 8'h00;
    localparam logic [7:0] ARRAY_SELECT_RST_BOOT = 8'hAA;
    localparam logic [7:0] ARRAY_SELECT_RST_OTHER = 8'h00;
    // ==========================================================
    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ==========================================================
    // Operating modes
    typedef enum logic [1:0] {
        FKAS_MODE_USER_PROG,
        FKAS_MODE_USER_BOOT,
        FKAS_MODE_BOOT,
        FKAS_MODE_PROGRAMMER
    } fkas_mode_t;
    // Register write strobe carried to the register file
    typedef struct packed {
        logic en;
        logic [3:0] addr;
        logic [7:0] data;
    } fkas_wr_t;
endpackage : fkas_pkg

// ==== fkas_axi_slave.sv ====
// AXI4-Lite slave front end that produces byte-wide register strobes
`timescale 1ns/1ps
module fkas_axi_slave
    import fkas_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // AXI4-Lite
    input wire logic [31:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [31:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Register side
    output fkas_wr_t wr,
    output logic [3:0] rd_addr,
    input wire logic [7:0] rd_data,
    input wire logic rd_hit
);
    logic aw_have_reg;
    logic w_have_reg;
    logic [3:0] aw_addr_reg;
    logic aw_ok_reg;
    logic [7:0] w_data_reg;
    logic w_lane0_reg;

    function automatic logic addr_ok(input logic [31:0] a);
        addr_ok = (a[31:4] == 28'h0000000) && (a[1:0] == 2'h0);
    endfunction : addr_ok

    assign awready = !aw_have_reg && !bvalid;
    assign wready = !w_have_reg && !bvalid;
    assign arready = !rvalid;
    assign rd_addr = araddr[3:0];

    // ==========================================================
    // Write channel capture and response
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            aw_addr_reg <= 4'h0;
            aw_ok_reg <= 1'b0;
            w_data_reg <= 8'h00;
            w_lane0_reg <= 1'b0;
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
        end else begin
            if (awvalid && awready) begin
                aw_have_reg <= 1'b1;
                aw_addr_reg <= awaddr[3:0];
                aw_ok_reg <= addr_ok(awaddr);
            end
            if (wvalid && wready) begin
                w_have_reg <= 1'b1;
                w_data_reg <= wdata[7:0];
                w_lane0_reg <= wstrb[0];
            end
            if (aw_have_reg && w_have_reg) begin
                aw_have_reg <= 1'b0;
                w_have_reg <= 1'b0;
                bvalid <= 1'b1;
                bresp <= aw_ok_reg ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    always_comb begin
        wr.en = aw_have_reg && w_have_reg && aw_ok_reg && w_lane0_reg;
        wr.addr = aw_addr_reg;
        wr.data = w_data_reg;
    end

    // ==========================================================
    // Read channel
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rvalid <= 1'b0;
            rdata <= 32'h00000000;
            rresp <= RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rdata <= {24'h000000, rd_data};
            rresp <= (addr_ok(araddr) && rd_hit) ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
        end
    end
endmodule : fkas_axi_slave

// ==== fkas_mode_latch.sv ====
// Captures the operating mode straps after reset release
`timescale 1ns/1ps
module fkas_mode_latch
    import fkas_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Mode straps
    input wire fkas_mode_t mode_in,
    // Captured mode
    output fkas_mode_t mode,
    output logic valid
);
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            valid <= 1'b0;
            mode <= FKAS_MODE_USER_PROG;
        end else if (!valid) begin
            valid <= 1'b1;
            mode <= mode_in;
        end
    end
endmodule : fkas_mode_latch

// ==== fkas_asserts.sv ====
// Concurrent checks on the flash key and array select bank ports
`timescale 1ns/1ps
module fkas_asserts
    import fkas_pkg::*;
(
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic RST_B,
    // Bus
    input wire logic S_AXI_AWREADY,
    input wire logic S_AXI_WREADY,
    input wire logic [31:0] S_AXI_RDATA,
    input wire logic S_AXI_RVALID,
    // Mode and download side
    input wire fkas_mode_t MODE,
    input wire logic RAM_EMULATION_ON,
    input wire logic EXEC_FROM_RAM,
    input wire logic DOWNLOAD_REQUEST_WR,
    input wire logic DOWNLOAD_DONE,
    // Flash control
    input wire logic DOWNLOAD_REQUEST,
    input wire logic ERASE_PROGRAM_PICK,
    input wire logic PROG_ERASE_EN,
    input wire logic SOFT_PROTECT,
    input wire logic USER_BOOT_SELECT
);
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RST_B);
    logic idle;
    logic dl_ok;
    assign idle = S_AXI_AWREADY && S_AXI_WREADY;
    assign dl_ok = DOWNLOAD_REQUEST_WR && !RAM_EMULATION_ON && EXEC_FROM_RAM;
    // ==========================================================
    // Assertions
    AST_PROTECT: assert property (SOFT_PROTECT != PROG_ERASE_EN)
        else $error("protect is not the inverse of enable");
    AST_DL_CAUSE: assert property (
        $rose(DOWNLOAD_REQUEST) |-> $past(dl_ok))
        else $error("download request set without its conditions");
    AST_DL_CLEAR: assert property (
        DOWNLOAD_DONE && !DOWNLOAD_REQUEST_WR |=> !DOWNLOAD_REQUEST)
        else $error("download request kept after completion");
    AST_PICK_CLEAR: assert property (
        DOWNLOAD_DONE && idle |=> !ERASE_PROGRAM_PICK)
        else $error("erase pick kept after completion");
    AST_PICK_HOLD: assert property (
        !DOWNLOAD_DONE && idle |=> $stable(ERASE_PROGRAM_PICK))
        else $error("erase pick changed without cause");
    AST_UB_MODE: assert property (
        MODE == FKAS_MODE_USER_PROG |-> !USER_BOOT_SELECT)
        else $error("user-boot array selected in user programming mode");
    AST_RD_UPPER: assert property (
        S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h0)
        else $error("upper read bits not zero");
    AST_DL_HOLD: assert property (
        DOWNLOAD_REQUEST && !DOWNLOAD_DONE |=> DOWNLOAD_REQUEST [*1])
        else $error("download request dropped without completion");
    COV_DL: cover property ($rose(DOWNLOAD_REQUEST));
    COV_UB: cover property ($rose(USER_BOOT_SELECT));
    COV_PE: cover property ($rose(PROG_ERASE_EN));
endmodule : fkas_asserts

bind fkas_top fkas_asserts fkas_asserts_inst (.CORE_CLK, .RST_B,
    .S_AXI_AWREADY, .S_AXI_WREADY, .S_AXI_RDATA, .S_AXI_RVALID, .MODE,
    .RAM_EMULATION_ON, .EXEC_FROM_RAM, .DOWNLOAD_REQUEST_WR, .DOWNLOAD_DONE,
    .DOWNLOAD_REQUEST, .ERASE_PROGRAM_PICK, .PROG_ERASE_EN, .SOFT_PROTECT,
    .USER_BOOT_SELECT);

// ==== fkas_tb_top.sv ====
// Self-checking testbench of the flash key and array select bank
`timescale 1ns/1ps
module fkas_tb_top
    import fkas_pkg::*;
;
    typedef struct packed {
        logic [31:0] a;
        logic [7:0] d;
        logic [7:0] q;
        logic [1:0] r;
        logic [2:0] f;
    } fkas_row_t;
    logic CORE_CLK = 1'b0;
    logic RST_B = 1'b0;
    logic [31:0] S_AXI_AWADDR = 32'h0;
    logic [31:0] S_AXI_WDATA = 32'h0;
    logic [31:0] S_AXI_ARADDR = 32'h0;
    logic [3:0] S_AXI_WSTRB = 4'hF;
    logic S_AXI_AWVALID = 1'b0;
    logic S_AXI_WVALID = 1'b0;
    logic S_AXI_BREADY = 1'b0;
    logic S_AXI_ARVALID = 1'b0;
    logic S_AXI_RREADY = 1'b0;
    logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY;
    logic S_AXI_RVALID;
    logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
    logic [31:0] S_AXI_RDATA;
    fkas_mode_t MODE = FKAS_MODE_BOOT;
    logic RAM_EMULATION_ON = 1'b0;
    // Download request is only set while running from RAM
    logic EXEC_FROM_RAM = 1'b1;
    logic DOWNLOAD_REQUEST_WR = 1'b0;
    logic DOWNLOAD_DONE = 1'b0;
    logic DOWNLOAD_REQUEST, ERASE_PROGRAM_PICK, PROG_ERASE_EN;
    logic SOFT_PROTECT, USER_BOOT_SELECT;
    int err_count = 0;
    int check_count = 0;
    fkas_row_t rows [9] = '{
        '{32'h0, 8'hFF, 8'h01, 2'h0, 3'h2}, '{32'h0, 8'h00, 8'h00, 2'h0, 3'h2},
        '{32'h4, 8'h5A, 8'h5A, 2'h0, 3'h4}, '{32'h4, 8'h5B, 8'h5B, 2'h0, 3'h2},
        '{32'h8, 8'hAA, 8'hAA, 2'h0, 3'h3}, '{32'h8, 8'hAB, 8'hAB, 2'h0, 3'h2},
        '{32'h10, 8'h12, 8'h0, RESP_SLVERR, 3'h2},
        '{32'h6, 8'h12, 8'h0, RESP_SLVERR, 3'h2},
        '{32'hC, 8'hFF, 8'h04, 2'h0, 3'h2}};

    fkas_top fkas_top_inst (.CORE_CLK, .RST_B, .S_AXI_AWADDR, .S_AXI_AWVALID,
        .S_AXI_AWREADY, .S_AXI_WDATA, .S_AXI_WSTRB, .S_AXI_WVALID,
        .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY,
        .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA,
        .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY, .MODE,
        .RAM_EMULATION_ON, .EXEC_FROM_RAM, .DOWNLOAD_REQUEST_WR,
        .DOWNLOAD_DONE, .DOWNLOAD_REQUEST, .ERASE_PROGRAM_PICK,
        .PROG_ERASE_EN, .SOFT_PROTECT, .USER_BOOT_SELECT);

    initial begin
        forever #5 CORE_CLK = ~CORE_CLK;
    end

    // ==========================================================
    // Helpers
    function automatic logic [31:0] flg();
        return {29'h0, PROG_ERASE_EN, SOFT_PROTECT, USER_BOOT_SELECT};
    endfunction : flg

    function automatic logic [31:0] dls();
        return {30'h0, DOWNLOAD_REQUEST, ERASE_PROGRAM_PICK};
    endfunction : dls

    task automatic end_of_test;
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [31:0] got, exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t mismatch got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic tmo(input int i);
        if (i > 40) begin
            err_count++;
            $display("ERROR %0t bus timeout", $time);
            end_of_test;
        end
    endtask : tmo

    task automatic wr(input logic [31:0] a, d, output logic [1:0] r);
        logic [2:0] hs;
        int i;
        @(posedge CORE_CLK);
        S_AXI_AWADDR <= a;
        S_AXI_WDATA <= d;
        {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} <= 3'h7;
        for (i = 0; i < 41; i++) begin
            @(negedge CORE_CLK);
            if (!(S_AXI_AWVALID | S_AXI_WVALID | S_AXI_BREADY)) break;
            hs = {S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID};
            if (hs[0]) r = S_AXI_BRESP;
            @(posedge CORE_CLK);
            {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} <=
                {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} & ~hs;
        end
        tmo(i);
    endtask : wr

    task automatic rd(input logic [31:0] a, output logic [31:0] d,
        output logic [1:0] r);
        logic [1:0] hs;
        int i;
        @(posedge CORE_CLK);
        S_AXI_ARADDR <= a;
        {S_AXI_ARVALID, S_AXI_RREADY} <= 2'h3;
        for (i = 0; i < 41; i++) begin
            @(negedge CORE_CLK);
            if (!(S_AXI_ARVALID | S_AXI_RREADY)) break;
            hs = {S_AXI_ARREADY, S_AXI_RVALID};
            if (hs[0]) {r, d} = {S_AXI_RRESP, S_AXI_RDATA};
            @(posedge CORE_CLK);
            {S_AXI_ARVALID, S_AXI_RREADY} <=
                {S_AXI_ARVALID, S_AXI_RREADY} & ~hs;
        end
        tmo(i);
    endtask : rd

    task automatic dl(input logic e, x, w, dn);
        @(posedge CORE_CLK);
        {RAM_EMULATION_ON, EXEC_FROM_RAM} <= {e, x};
        {DOWNLOAD_REQUEST_WR, DOWNLOAD_DONE} <= {w, dn};
        @(posedge CORE_CLK);
        {DOWNLOAD_REQUEST_WR, DOWNLOAD_DONE} <= 2'h0;
        @(negedge CORE_CLK);
    endtask : dl

    task automatic rst(input fkas_mode_t m);
        @(posedge CORE_CLK);
        RST_B <= 1'b0;
        MODE <= m;
        repeat (3) @(posedge CORE_CLK);
        RST_B <= 1'b1;
        repeat (2) @(posedge CORE_CLK);
    endtask : rst

    // ==========================================================
    // Main sequence
    initial begin
        logic [31:0] q;
        logic [1:0] r, rw;
        int k;
        rst(FKAS_MODE_BOOT);
        for (k = 0; k < 9; k++) begin
            wr(rows[k].a, {24'h0, rows[k].d}, rw);
            rd(rows[k].a, q, r);
            chk({28'h0, rw, r}, {28'h0, rows[k].r, rows[k].r});
            if (r === RESP_OKAY) chk(q, {24'h0, rows[k].q});
            chk(flg(), {29'h0, rows[k].f});
        end
        $display("register table test done");
        for (k = 0; k < 4; k++) begin
            rst(fkas_mode_t'(k));
            rd(32'h8, q, r);
            chk(q, (k == 1) ? 32'hAA : 32'h0);
            wr(32'h8, 32'hAA, r);
            chk(flg(), (k == 0) ? 32'h2 : 32'h3);
        end
        $display("mode test done");
        wr(32'h4, 32'hA5, r);
        rd(32'hC, q, r);
        chk(q, 32'hD);
        dl(1'b1, 1'b1, 1'b1, 1'b0);
        chk(dls(), 32'h0);
        dl(1'b0, 1'b0, 1'b1, 1'b0);
        chk(dls(), 32'h0);
        dl(1'b0, 1'b1, 1'b1, 1'b0);
        chk(dls(), 32'h2);
        wr(32'h0, 32'h1, r);
        chk(dls(), 32'h3);
        dl(1'b0, 1'b1, 1'b0, 1'b1);
        chk(dls(), 32'h0);
        dl(1'b0, 1'b1, 1'b1, 1'b1);
        chk(dls(), 32'h2);
        dl(1'b0, 1'b1, 1'b0, 1'b1);
        chk(dls(), 32'h0);
        wr(32'h4, 32'h5A, r);
        dl(1'b0, 1'b1, 1'b1, 1'b0);
        chk(dls(), 32'h0);
        $display("download test done");
        end_of_test;
    end
endmodule : fkas_tb_top
